// *** bench/hisp_host_model.sv ***
// Host model: SPI master, mode 3, 5 MHz serial clock.
// Assumes the bench calls xfer by hierarchical name.
`timescale 1ns/1ps
module hisp_host_model (
   // SPI master pins
   output logic spi_sclk,
   output logic spi_cs_n
);
   initial begin
      spi_sclk = 1'b1;
      spi_cs_n = 1'b1;
   end
   // Length kept legal before framing
   task automatic xfer(input int nbytes);
      int n;
      n = (nbytes < 8) ? 8 : (nbytes > 4096) ? 4096 : nbytes;
      n = n - n % 4;
      #37 spi_cs_n = 1'b0;
      repeat (n * 8) begin
         #100 spi_sclk = 1'b0;
         #100 spi_sclk = 1'b1;
      end
      #100 spi_cs_n = 1'b1;
   endtask : xfer
endmodule : hisp_host_model

// *** bench/test_hisp_top.sv ***
// Self-checking bench for the interface select and status block.
// Assumes hisp_pkg and the host model are compiled first.
`timescale 1ns/1ps
module test_hisp_top;
   import hisp_pkg::*;
   logic mclk, rst, ce, sys_reset_n, switch1_n, switch2_n, dsr_n;
   logic uart_cts_n, spi_sclk, spi_cs_n, boot_done, uart_cmd_seen;
   logic data_activity, rx_buf_full, uart_rts_req, banner_busy;
   logic cmd_mode_cfg, drdy_enable, norx_enable, parity_even_cfg, baud_wr;
   logic [1:0] dsr_use;
   logic [15:0] baud_div_cfg, baud_div;
   hisp_link_e link_state;
   hisp_led_s led;
   hisp_boot_s boot;
   hisp_sel_e sel;
   logic uart_rts_n, uart_tx_enable, uart_cts_ok, spi_enable;
   logic data_ready_out, receive_full_out, parity_even, command_mode;
   logic disconnect_req, stop_req, connect_req;
   int failures, checks;
   int conn_cnt = 0;
   int disc_cnt = 0;

   hisp_top #(.HOLD_CYC(200), .DRDY_CYC(8), .FLASH_LEN(4)) i_hisp_top (
      .mclk, .rst, .ce, .sys_reset_n, .switch1_n, .switch2_n, .dsr_n,
      .uart_cts_n, .spi_sclk, .spi_cs_n, .boot_done, .uart_cmd_seen,
      .data_activity, .rx_buf_full, .uart_rts_req, .banner_busy,
      .dsr_use, .cmd_mode_cfg, .link_state, .drdy_enable, .norx_enable,
      .parity_even_cfg, .baud_wr, .baud_div_cfg, .led, .uart_rts_n,
      .uart_tx_enable, .uart_cts_ok, .spi_enable, .data_ready_out,
      .receive_full_out, .parity_even, .baud_div, .command_mode,
      .disconnect_req, .stop_req, .connect_req, .boot, .sel);
   hisp_host_model i_hisp_host_model (.spi_sclk, .spi_cs_n);

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (connect_req === 1'b1) conn_cnt <= conn_cnt + 1;
      if (disconnect_req === 1'b1) disc_cnt <= disc_cnt + 1;
   end

   task automatic print_verdict();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick
   task automatic wait_sel(input hisp_sel_e s);
      for (int i = 0; i < 300 && sel !== s; i++) tick(1);
      if (sel !== s) begin
         chk(sel, s);
         print_verdict();
      end
   endtask : wait_sel
   task automatic wait_led(input hisp_led_s v);
      for (int i = 0; i < 30 && led !== v; i++) tick(1);
      if (led !== v) begin
         chk(led, v);
         print_verdict();
      end
   endtask : wait_led
   task automatic toggles(input int n, output int cnt);
      logic last;
      cnt = 0;
      last = data_ready_out;
      repeat (n) begin
         tick(1);
         if (data_ready_out !== last) cnt++;
         last = data_ready_out;
      end
   endtask : toggles
   task automatic do_reset(input logic s1, input logic s2);
      rst <= 1'b1;
      switch1_n <= s1;
      switch2_n <= s2;
      boot_done <= 1'b0;
      tick(5);
      rst <= 1'b0;
      tick(6);
   endtask : do_reset

   // ****
   // Scenarios
   // ****
   task automatic t_reset();
      rst <= 1'b1;
      tick(2);
      chk(led, LED_DARK);
      chk(sel, HISP_SEL_WAIT);
      chk(baud_div, DEF_BAUD_DIV);
      chk(parity_even, 1'b0);
      chk(receive_full_out, 1'b0);
      chk(spi_enable, 1'b0);
      do_reset(1'b1, 1'b1);
   endtask : t_reset
   task automatic t_leds();
      hisp_link_e st[4] = '{HISP_IDLE, HISP_IDLE, HISP_CONNECTING,
                            HISP_CONNECTED};
      logic cm[4] = '{1'b0, 1'b1, 1'b0, 1'b0};
      hisp_led_s ex[4] = '{LED_DATA_IDLE, LED_CMD_IDLE, LED_CONNECTING,
                           LED_CONNECTED};
      for (int i = 0; i < 4; i++) begin
         link_state <= st[i];
         cmd_mode_cfg <= cm[i];
         tick(3);
         chk(led, ex[i]);
      end
      data_activity <= 1'b1;
      tick(1);
      data_activity <= 1'b0;
      wait_led(LED_DARK);
      wait_led(LED_CONNECTED);
      chk(led, LED_CONNECTED);
      link_state <= HISP_CONNECTING;
      data_activity <= 1'b1;
      tick(1);
      data_activity <= 1'b0;
      wait_led(LED_DARK);
      wait_led(LED_CONNECTING);
      chk(led, LED_CONNECTING);
      link_state <= HISP_IDLE;
   endtask : t_leds
   task automatic t_boot();
      do_reset(1'b0, 1'b1);
      chk(boot, 3'b100);
      do_reset(1'b0, 1'b0);
      chk(boot, 3'b110);
      tick(210);
      chk(boot.bootloader, 1'b0);
      chk(boot.factory_reset, 1'b1);
      do_reset(1'b0, 1'b0);
      tick(100);
      switch2_n <= 1'b1;
      tick(4);
      switch2_n <= 1'b0;
      tick(150);
      chk(boot.factory_reset, 1'b0);
   endtask : t_boot
   task automatic t_uart();
      int n;
      do_reset(1'b1, 1'b1);
      boot_done <= 1'b1;
      wait_sel(HISP_SEL_DETECT);
      drdy_enable <= 1'b0;
      tick(2);
      toggles(40, n);
      chk(n, 0);
      drdy_enable <= 1'b1;
      uart_cmd_seen <= 1'b1;
      tick(1);
      uart_cmd_seen <= 1'b0;
      wait_sel(HISP_SEL_UART);
      tick(1);
      chk(spi_enable, 1'b0);
      toggles(40, n);
      chk(n, 0);
      uart_cts_n <= 1'b0;
      uart_rts_req <= 1'b1;
      tick(4);
      chk(uart_cts_ok, 1'b1);
      chk(uart_rts_n, 1'b0);
      uart_cts_n <= 1'b1;
      uart_rts_req <= 1'b0;
      tick(4);
      chk(uart_cts_ok, 1'b0);
      chk(uart_rts_n, 1'b1);
      i_hisp_host_model.xfer(8);
      tick(3);
      chk(sel, HISP_SEL_UART);
   endtask : t_uart
   task automatic t_spi();
      int n;
      do_reset(1'b1, 1'b1);
      boot_done <= 1'b1;
      wait_sel(HISP_SEL_DETECT);
      toggles(40, n);
      chk(n >= 3, 1'b1);
      banner_busy <= 1'b1;
      fork
         i_hisp_host_model.xfer(8);
         begin
            wait_sel(HISP_SEL_SPI);
            chk(uart_tx_enable, 1'b1);
            banner_busy <= 1'b0;
            tick(3);
            chk(uart_tx_enable, 1'b0);
            chk(spi_enable, 1'b1);
         end
      join
      rx_buf_full <= 1'b1;
      tick(3);
      chk(receive_full_out, 1'b0);
      chk(data_ready_out, 1'b1);
      norx_enable <= 1'b1;
      tick(3);
      chk(receive_full_out, 1'b1);
      rx_buf_full <= 1'b0;
      norx_enable <= 1'b0;
      boot_done <= 1'b0;
      sys_reset_n <= 1'b0;
      tick(5);
      sys_reset_n <= 1'b1;
      tick(3);
      chk(sel, HISP_SEL_WAIT);
   endtask : t_spi
   task automatic t_misc();
      int c0;
      do_reset(1'b1, 1'b1);
      parity_even_cfg <= 1'b1;
      baud_div_cfg <= 16'h0001;
      baud_wr <= 1'b1;
      tick(1);
      baud_wr <= 1'b0;
      tick(2);
      chk(baud_div, MIN_DIV);
      chk(parity_even, 1'b1);
      for (int u = 0; u < 4; u++) begin
         c0 = disc_cnt;
         dsr_use <= u[1:0];
         dsr_n <= 1'b0;
         tick(4);
         chk(command_mode, u[1:0] == DSR_CMD);
         chk(stop_req, 1'b0);
         dsr_n <= 1'b1;
         tick(4);
         chk(disc_cnt - c0, u[1:0] == DSR_DISC);
         chk(stop_req, u[1:0] == DSR_STOP);
         chk(uart_tx_enable, u[1:0] != DSR_UART_EN);
      end
      c0 = conn_cnt;
      switch2_n <= 1'b0;
      tick(4);
      switch2_n <= 1'b1;
      tick(4);
      chk(conn_cnt - c0, 1);
      switch1_n <= 1'b0;
      sys_reset_n <= 1'b0;
      tick(5);
      sys_reset_n <= 1'b1;
      tick(6);
      chk(baud_div, DEF_BAUD_DIV);
      chk(parity_even, 1'b0);
      switch1_n <= 1'b1;
   endtask : t_misc

   initial begin
      failures = 0;
      checks = 0;
      rst = 1'b1;
      ce = 1'b1;
      sys_reset_n = 1'b1;
      switch1_n = 1'b1;
      switch2_n = 1'b1;
      dsr_n = 1'b1;
      uart_cts_n = 1'b1;
      boot_done = 1'b0;
      uart_cmd_seen = 1'b0;
      data_activity = 1'b0;
      rx_buf_full = 1'b0;
      uart_rts_req = 1'b0;
      banner_busy = 1'b0;
      dsr_use = DSR_CMD;
      cmd_mode_cfg = 1'b0;
      link_state = HISP_IDLE;
      drdy_enable = 1'b1;
      norx_enable = 1'b0;
      parity_even_cfg = 1'b0;
      baud_wr = 1'b0;
      baud_div_cfg = DEF_BAUD_DIV;
      t_reset();
      t_leds();
      t_boot();
      t_uart();
      t_spi();
      t_misc();
      print_verdict();
   end
endmodule : test_hisp_top

// *** design/hisp_pkg.sv ***
// Package for the host interface select and status block.
// Assumes a 40 MHz core clock; all settings arrive as plain ports.
package hisp_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_HZ = 40_000_000;
   localparam int FACTORY_HOLD_S = 10;
   localparam longint FACTORY_HOLD_CYC = longint'(FACTORY_HOLD_S) * CLK_HZ;
   localparam int DRDY_TOGGLE_US = 100;
   localparam int DRDY_TOGGLE_CYC = DRDY_TOGGLE_US * (CLK_HZ / 1_000_000);
   localparam int FLASH_US = 50_000;
   localparam int FLASH_CYC = FLASH_US * (CLK_HZ / 1_000_000);
   localparam int SPI_DETECT_EDGES = 8;
   localparam int MAX_BAUD = 3_000_000;
   localparam int MIN_DIV = CLK_HZ / MAX_BAUD;
   localparam logic [15:0] DEF_BAUD_DIV = 16'h015b;

   // ****************************************
   // DSR use and link states
   // ****************************************
   localparam logic [1:0] DSR_CMD = 2'h0;
   localparam logic [1:0] DSR_DISC = 2'h1;
   localparam logic [1:0] DSR_UART_EN = 2'h2;
   localparam logic [1:0] DSR_STOP = 2'h3;

   typedef enum logic [1:0] {
      HISP_IDLE,
      HISP_CONNECTING,
      HISP_CONNECTED
   } hisp_link_e;

   typedef enum logic [1:0] {
      HISP_SEL_WAIT,
      HISP_SEL_DETECT,
      HISP_SEL_UART,
      HISP_SEL_SPI
   } hisp_sel_e;

   // Active-low colour outputs
   typedef struct packed {
      logic green_n;
      logic blue_n;
      logic red_n;
   } hisp_led_s;

   // Boot outcome caught from the switches
   typedef struct packed {
      logic uart_defaults;
      logic bootloader;
      logic factory_reset;
   } hisp_boot_s;

   localparam hisp_led_s LED_DATA_IDLE = 3'b011;
   localparam hisp_led_s LED_CMD_IDLE = 3'b010;
   localparam hisp_led_s LED_CONNECTING = 3'b100;
   localparam hisp_led_s LED_CONNECTED = 3'b101;
   localparam hisp_led_s LED_DARK = 3'b111;

endpackage : hisp_pkg

// *** design/hisp_sync.sv ***
// Two-flop synchroniser for pins from outside the core clock.
// Assumes the asynchronous active-high reset of the block.
`timescale 1ns/1ps
module hisp_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock, reset and enable
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // Data
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         meta <= RST_VAL;
         q <= RST_VAL;
      end else if (ce) begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : hisp_sync

// *** design/hisp_top.sv ***
// Host interface selection, startup switches and status lights.
// Assumes pins are asynchronous; UART/SPI engines sit outside.
// Functional notes
// [RL1] Colour status outputs are active low.
// [RL2] Colour codes for data idle, command idle, connecting, connected.
// [RL3] Lit indication flashes on data activity when connecting or connected.
// [RL4] First switch low at startup restores default UART settings.
// [RL5] Second switch requests a connection to a peripheral.
// [RL6] Both switches low at startup enter bootloader.
// [RL7] Both held low ten seconds: leave bootloader, factory defaults.
// [RL8] DSR enters command mode, disconnects, gates UART or stop mode.
// [RL9] Only one of UART or SPI is active at a time; code enables both during detection and while the banner runs once SPI wins.
// [RL10] After boot, watch both links for host activity.
// [RL11] Startup banner always goes out on UART transmit; code blocks it while the DSR_UART_EN gate holds UART off.
// [RL12] Data-ready toggles periodically during SPI detection.
// [RL13] Eight SPI clocks select SPI and disable UART.
// [RL14] UART command during detection selects UART, stops toggle, SPI off.
// [RL15] Frame is 8 data bits, even or no parity, 1 stop; 8N1 default.
// [RL16] Baud divider programmable up to 3 Mbaud.
// [RL17] CTS is an input, RTS an output.
// [RL18] SPI port is slave only.
// [RL19] Data-ready output enabled after reset, can be disabled.
// [RL20] Receive-full output disabled after reset.
// [RL21] Host keeps SPI clock at or below 10 MHz.
// [RL22] Host uses SPI mode 1 or 3.
// [RL23] Host transfers 8 to 4096 bytes, multiple of 4.
// [RL24] RTS and CTS are active low.
// [RL25] External system reset input is active low.
// [RL26] SPI chip select is active low and frames transactions.
`timescale 1ns/1ps
module hisp_top
   import hisp_pkg::*;
#(
   parameter longint HOLD_CYC = FACTORY_HOLD_CYC,
   parameter int DRDY_CYC = DRDY_TOGGLE_CYC,
   parameter int FLASH_LEN = FLASH_CYC
) (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic sys_reset_n,
   // Switch and DSR pins
   input wire logic switch1_n,
   input wire logic switch2_n,
   input wire logic dsr_n,
   // UART and SPI pins
   input wire logic uart_cts_n,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   // Events from the link engines (core clock)
   input wire logic boot_done,
   input wire logic uart_cmd_seen,
   input wire logic data_activity,
   input wire logic rx_buf_full,
   input wire logic uart_rts_req,
   input wire logic banner_busy,
   // Configuration
   input wire logic [1:0] dsr_use,
   input wire logic cmd_mode_cfg,
   input wire hisp_pkg::hisp_link_e link_state,
   input wire logic drdy_enable,
   input wire logic norx_enable,
   input wire logic parity_even_cfg,
   input wire logic baud_wr,
   input wire logic [15:0] baud_div_cfg,
   // Status light outputs
   output hisp_pkg::hisp_led_s led,
   // Link outputs
   output logic uart_rts_n,
   output logic uart_tx_enable,
   output logic uart_cts_ok,
   output logic spi_enable,
   output logic data_ready_out,
   output logic receive_full_out,
   output logic parity_even,
   output logic [15:0] baud_div,
   // Control outputs
   output logic command_mode,
   output logic disconnect_req,
   output logic stop_req,
   output logic connect_req,
   output hisp_pkg::hisp_boot_s boot,
   output hisp_pkg::hisp_sel_e sel
);
   import hisp_pkg::*;

   // ****************************************
   // Input synchronisers
   // ****************************************
   logic [6:0] pins_s;
   logic sw1_s, sw2_s, dsr_s, cts_s, sclk_s, cs_s, nrst_s;

   hisp_sync #(.WIDTH(7), .RST_VAL(7'h7f)) u_sync (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .d({switch1_n, switch2_n, dsr_n, uart_cts_n, spi_sclk, spi_cs_n,
          sys_reset_n}),
      .q(pins_s)
   );
   assign {sw1_s, sw2_s, dsr_s, cts_s, sclk_s, cs_s, nrst_s} = pins_s;

   // Soft reset from the external active-low pin
   logic srst;
   assign srst = !nrst_s; // RL25

   // ****************************************
   // Startup switch sampling
   // ****************************************
   logic sampled;
   logic [1:0] settle;
   logic take;
   logic [35:0] hold_cnt;

   // Sample only once both sync stages hold real pin levels
   assign take = settle[1] && !sampled && !srst;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         settle <= '0;
         sampled <= 1'b0;
         boot <= '0;
         hold_cnt <= '0;
      end else if (ce) begin
         settle <= {settle[0], 1'b1};
         if (srst) begin
            sampled <= 1'b0;
            boot <= '0;
            hold_cnt <= '0;
         end else if (take) begin
            sampled <= 1'b1;
            boot.uart_defaults <= !sw1_s; // RL4
            boot.bootloader <= !sw1_s && !sw2_s; // RL6
         end else if (boot.bootloader) begin
            if (sw1_s || sw2_s) begin
               hold_cnt <= HOLD_CYC[35:0];
            end else if (hold_cnt == HOLD_CYC[35:0] - 36'h1) begin
               boot.bootloader <= 1'b0; // RL7
               boot.factory_reset <= 1'b1; // RL7
            end else if (hold_cnt != HOLD_CYC[35:0]) begin
               hold_cnt <= hold_cnt + 36'h1;
            end
         end
      end
   end

   // Second switch falling edge requests a connection
   logic sw2_d;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sw2_d <= 1'b1;
         connect_req <= 1'b0;
      end else if (ce) begin
         sw2_d <= sw2_s;
         connect_req <= sampled && !boot.bootloader && sw2_d && !sw2_s; // RL5
      end
   end

   // ****************************************
   // Interface selection
   // ****************************************
   logic sclk_d;
   logic [3:0] edge_cnt;
   logic [$clog2(DRDY_CYC+1)-1:0] drdy_cnt;
   logic drdy_tog;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sel <= HISP_SEL_WAIT;
         sclk_d <= 1'b1;
         edge_cnt <= '0;
      end else if (ce) begin
         sclk_d <= sclk_s;
         if (srst) begin
            sel <= HISP_SEL_WAIT;
            edge_cnt <= '0;
         end else begin
            unique case (sel)
               HISP_SEL_WAIT: begin
                  if (boot_done && !boot.bootloader) begin
                     sel <= HISP_SEL_DETECT; // RL10
                  end
               end
               HISP_SEL_DETECT: begin
                  if (uart_cmd_seen) begin
                     sel <= HISP_SEL_UART; // RL14
                  end else if (edge_cnt == 4'(SPI_DETECT_EDGES)) begin
                     sel <= HISP_SEL_SPI; // RL13
                  end else if (!cs_s && sclk_s && !sclk_d) begin
                     edge_cnt <= edge_cnt + 4'h1; // RL26
                  end
               end
               HISP_SEL_UART: ;
               HISP_SEL_SPI: ;
            endcase
         end
      end
   end

   // Detection pulse train on data-ready
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         drdy_cnt <= '0;
         drdy_tog <= 1'b0;
      end else if (ce) begin
         if (sel != HISP_SEL_DETECT) begin
            drdy_cnt <= '0;
            drdy_tog <= 1'b0;
         end else if (drdy_cnt == ($bits(drdy_cnt))'(DRDY_CYC - 1)) begin
            drdy_cnt <= '0;
            drdy_tog <= !drdy_tog; // RL12
         end else begin
            drdy_cnt <= drdy_cnt + 1'b1;
         end
      end
   end

   // ****************************************
   // DSR control
   // ****************************************
   logic dsr_d;
   logic uart_gate;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dsr_d <= 1'b1;
         command_mode <= 1'b0;
         disconnect_req <= 1'b0;
         stop_req <= 1'b0;
         uart_gate <= 1'b1;
      end else if (ce) begin
         dsr_d <= dsr_s;
         disconnect_req <= 1'b0;
         unique case (dsr_use)
            DSR_CMD: command_mode <= cmd_mode_cfg || !dsr_s; // RL8
            DSR_DISC: begin
               command_mode <= cmd_mode_cfg;
               disconnect_req <= dsr_d && !dsr_s; // RL8
            end
            DSR_UART_EN: begin
               command_mode <= cmd_mode_cfg;
               uart_gate <= !dsr_s; // RL8
            end
            DSR_STOP: begin
               command_mode <= cmd_mode_cfg;
               stop_req <= dsr_s; // RL8
            end
         endcase
         if (dsr_use != DSR_UART_EN) begin
            uart_gate <= 1'b1;
         end
         if (dsr_use != DSR_STOP) begin
            stop_req <= 1'b0;
         end
      end
   end

   // ****************************************
   // Link enables, flow control, frame setup
   // ****************************************
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         uart_tx_enable <= 1'b1;
         spi_enable <= 1'b0;
         uart_rts_n <= 1'b1;
         uart_cts_ok <= 1'b0;
         data_ready_out <= 1'b0;
         receive_full_out <= 1'b0;
      end else if (ce) begin
         // Banner keeps transmit alive even once SPI wins
         uart_tx_enable <= uart_gate &&
                           (sel != HISP_SEL_SPI || banner_busy); // RL9 RL11
         spi_enable <= sel == HISP_SEL_SPI || sel == HISP_SEL_DETECT; // RL9 RL18
         uart_rts_n <= !(uart_rts_req && uart_gate &&
                         sel != HISP_SEL_SPI); // RL17 RL24
         uart_cts_ok <= !cts_s; // RL17 RL24
         if (!drdy_enable) begin
            data_ready_out <= 1'b0; // RL19
         end else if (sel == HISP_SEL_DETECT) begin
            data_ready_out <= drdy_tog; // RL12
         end else begin
            data_ready_out <= sel == HISP_SEL_SPI && rx_buf_full; // RL19
         end
         receive_full_out <= norx_enable && sel == HISP_SEL_SPI &&
                             rx_buf_full; // RL20
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         parity_even <= 1'b0; // RL15
         baud_div <= DEF_BAUD_DIV;
      end else if (ce) begin
         if (take && !sw1_s) begin
            parity_even <= 1'b0; // RL4
            baud_div <= DEF_BAUD_DIV;
         end else if (baud_wr) begin
            parity_even <= parity_even_cfg; // RL15
            baud_div <= (baud_div_cfg < 16'(MIN_DIV)) ?
                        16'(MIN_DIV) : baud_div_cfg; // RL16
         end
      end
   end

   // ****************************************
   // Status lights
   // ****************************************
   logic [$clog2(FLASH_LEN+1)-1:0] flash_cnt;
   hisp_led_s next_led;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         flash_cnt <= '0;
      end else if (ce) begin
         if (data_activity) begin
            flash_cnt <= ($bits(flash_cnt))'(FLASH_LEN);
         end else if (flash_cnt != '0) begin
            flash_cnt <= flash_cnt - 1'b1;
         end
      end
   end

   always_comb begin
      unique case (link_state)
         HISP_CONNECTING: next_led = LED_CONNECTING; // RL2
         HISP_CONNECTED: next_led = LED_CONNECTED; // RL2
         default: next_led = command_mode ? LED_CMD_IDLE
                                          : LED_DATA_IDLE; // RL2
      endcase
      if (link_state != HISP_IDLE && flash_cnt != '0) begin
         next_led = LED_DARK; // RL3
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         led <= LED_DARK; // RL1
      end else if (ce) begin
         led <= next_led; // RL1
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   a_one_link: assert property (@(posedge mclk) disable iff (rst) // RL9
      ce && sel == HISP_SEL_SPI |=> uart_rts_n)
      else $error("RTS asserted while SPI selected");
   a_spi_select: assert property (@(posedge mclk) disable iff (rst) // RL13
      ce && !srst && sel == HISP_SEL_DETECT && !uart_cmd_seen &&
      edge_cnt == 4'(SPI_DETECT_EDGES) |=> sel == HISP_SEL_SPI)
      else $error("SPI not selected after eight clocks");
   a_uart_select: assert property (@(posedge mclk) disable iff (rst) // RL14
      ce && !srst && sel == HISP_SEL_DETECT && uart_cmd_seen
      |=> sel == HISP_SEL_UART)
      else $error("UART not selected on command");
   a_drdy_quiet: assert property (@(posedge mclk) disable iff (rst) // RL14
      sel == HISP_SEL_UART && $past(sel) == HISP_SEL_UART && ce
      |=> !data_ready_out)
      else $error("Data-ready toggles after UART chosen");
   a_boot_enter: assert property (@(posedge mclk) disable iff (rst) // RL6
      ce && take && !sw1_s && !sw2_s |=> boot.bootloader)
      else $error("Bootloader not entered");
   a_uart_default: assert property (@(posedge mclk) disable iff (rst) // RL4
      ce && take && !sw1_s |=> boot.uart_defaults)
      else $error("UART defaults not flagged");
   a_led_connect: assert property (@(posedge mclk) disable iff (rst) // RL2
      ce && link_state == HISP_CONNECTED && flash_cnt == '0
      |=> led == LED_CONNECTED)
      else $error("Wrong connected colour");
   a_led_flash: assert property (@(posedge mclk) disable iff (rst) // RL3
      ce && link_state == HISP_CONNECTING && flash_cnt != '0
      |=> led == LED_DARK)
      else $error("No flash on activity");
   a_norx_off: assert property (@(posedge mclk) disable iff (rst) // RL20
      ce && !norx_enable |=> !receive_full_out)
      else $error("Receive-full driven while disabled");
   a_drdy_off: assert property (@(posedge mclk) disable iff (rst) // RL19
      ce && !drdy_enable |=> !data_ready_out)
      else $error("Data-ready driven while disabled");

   c_spi_win: cover property (@(posedge mclk) sel == HISP_SEL_SPI);
   c_uart_win: cover property (@(posedge mclk) sel == HISP_SEL_UART);
   c_factory: cover property (@(posedge mclk) boot.factory_reset);
   c_flash: cover property (@(posedge mclk) led == LED_DARK &&
      link_state == HISP_CONNECTED);

endmodule : hisp_top
